// *** verilog/cpd_pkg.sv ***
`default_nettype none
package cpd_pkg;
	// ==========================================================
	// Instruction field positions
	localparam int COND_HI     = 31;
	localparam int COND_LO     = 28;
	localparam int CLS_HI      = 27;
	localparam int OP_CLS_LO   = 24;
	localparam int XF_CLS_LO   = 25;
	localparam int PRE_BIT     = 24;
	localparam int UP_BIT      = 23;
	localparam int LEN_BIT     = 22;
	localparam int WB_BIT      = 21;
	localparam int LOAD_BIT    = 20;
	localparam int OPC_HI      = 23;
	localparam int OPC_LO      = 20;
	localparam int FSRC_HI     = 19;
	localparam int FSRC_LO     = 16;
	localparam int TGT_HI      = 15;
	localparam int TGT_LO      = 12;
	localparam int NUM_HI      = 11;
	localparam int NUM_LO      = 8;
	localparam int INFO_HI     = 7;
	localparam int INFO_LO     = 5;
	localparam int OP_FLAG_BIT = 4;
	localparam int SSRC_HI     = 3;
	localparam int SSRC_LO     = 0;
	localparam int OFS_HI      = 7;
	localparam int OFS_LO      = 0;

	// ==========================================================
	// Class codes and constants
	localparam logic [3:0]  DATA_OP_CODE = 4'he;
	localparam logic [2:0]  XFER_CODE    = 3'h6;
	localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
	localparam logic [4:0]  SHORT_WORDS  = 5'h01;
	localparam logic [4:0]  LONG_WORDS   = 5'h10;
	localparam logic [7:0]  NO_CP_LIMIT  = 8'h40;
	localparam logic [7:0]  ZERO_CNT     = 8'h00;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

	// Flag positions in the flags vector {n,z,c,v}
	localparam int FN = 3;
	localparam int FZ = 2;
	localparam int FC = 1;
	localparam int FV = 0;

	// Data operation codes used by the coprocessor
	localparam logic [3:0] OPC_ADD = 4'h0;
	localparam logic [3:0] OPC_SUB = 4'h1;
	localparam logic [3:0] OPC_AND = 4'h2;
	localparam logic [3:0] OPC_OR  = 4'h3;

	typedef enum logic [2:0] {
		CPD_IDLE  = 3'b000,
		CPD_OFFER = 3'b001,
		CPD_XREQ  = 3'b010,
		CPD_XWAIT = 3'b011,
		CPD_XGAP  = 3'b100
	} cpd_state_t;

	// Condition field evaluated against the current flags
	function automatic logic cpd_cond_pass(input logic [3:0] cond, input logic [3:0] f);
		logic r;
		r = 1'b0;
		unique case (cond)
			4'h0: r = f[FZ];
			4'h1: r = !f[FZ];
			4'h2: r = f[FC];
			4'h3: r = !f[FC];
			4'h4: r = f[FN];
			4'h5: r = !f[FN];
			4'h6: r = f[FV];
			4'h7: r = !f[FV];
			4'h8: r = f[FC] && !f[FZ];
			4'h9: r = !f[FC] || f[FZ];
			4'ha: r = f[FN] == f[FV];
			4'hb: r = f[FN] != f[FV];
			4'hc: r = !f[FZ] && (f[FN] == f[FV]);
			4'hd: r = f[FZ] || (f[FN] != f[FV]);
			4'he: r = 1'b1;
			4'hf: r = 1'b0;
		endcase
		return r;
	endfunction
endpackage
`default_nettype wire

// *** verilog/cpd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cpd_if;
	logic        req_valid;   // Core offers an instruction
	logic [31:0] req_instr;   // Instruction word offered
	logic        req_accept;  // Numbered coprocessor takes it, one cycle
	logic [4:0]  xfer_words;  // Word count chosen by the coprocessor
	logic        word_strobe; // One word moved, one cycle
	logic [31:0] ld_data;     // Memory word going to the coprocessor
	logic [31:0] st_data;     // Coprocessor word going to memory

	modport core (
		output req_valid,
		output req_instr,
		input  req_accept,
		input  xfer_words,
		output word_strobe,
		output ld_data,
		input  st_data
	);

	modport cop (
		input  req_valid,
		input  req_instr,
		output req_accept,
		output xfer_words,
		input  word_strobe,
		input  ld_data,
		output st_data
	);
endinterface
`default_nettype wire

// *** verilog/cpd_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpd_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        instr_valid_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [3:0]  flags_i,
	input  wire logic [31:0] base_i,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i,
	output logic             instr_ready_o,
	output logic             undef_trap_o,
	output logic             skip_o,
	output logic             done_o,
	output logic             wb_en_o,
	output logic [31:0]      wb_value_o,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	output logic [7:0]       busy_cycles_o,
	cpd_if.core              link
);
	// ==========================================================
	// Decode
	cpd_pkg::cpd_state_t state_q;
	logic        is_op;
	logic        is_xfer;
	logic        cond_ok;
	logic        take;
	logic [31:0] ofs;
	logic [31:0] moved_base;

	assign is_op   = instr_i[cpd_pkg::CLS_HI:cpd_pkg::OP_CLS_LO] == cpd_pkg::DATA_OP_CODE
	                 && !instr_i[cpd_pkg::OP_FLAG_BIT];
	assign is_xfer = instr_i[cpd_pkg::CLS_HI:cpd_pkg::XF_CLS_LO] == cpd_pkg::XFER_CODE;
	assign cond_ok = cpd_pkg::cpd_cond_pass(instr_i[cpd_pkg::COND_HI:cpd_pkg::COND_LO],
	                                        flags_i);
	assign take    = instr_valid_i && (state_q == cpd_pkg::CPD_IDLE) && (is_op || is_xfer);
	// Word offset scaled to bytes, then applied up or down
	assign ofs        = {22'h000000, instr_i[cpd_pkg::OFS_HI:cpd_pkg::OFS_LO], 2'h0};
	assign moved_base = instr_i[cpd_pkg::UP_BIT] ? base_i + ofs : base_i - ofs;

	// ==========================================================
	// Held instruction state
	logic [31:0] instr_q;
	logic        load_q;
	logic        wb_q;
	logic [31:0] new_base_q;
	logic [4:0]  left_q;
	logic [7:0]  busy_q;

	// Capture the instruction once it is taken
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			instr_q    <= cpd_pkg::ZERO_WORD;
			load_q     <= 1'b0;
			wb_q       <= 1'b0;
			new_base_q <= cpd_pkg::ZERO_WORD;
		end else if (take && cond_ok) begin
			instr_q    <= instr_i;
			load_q     <= is_xfer && instr_i[cpd_pkg::LOAD_BIT];
			wb_q       <= is_xfer && instr_i[cpd_pkg::WB_BIT];
			new_base_q <= moved_base;
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= cpd_pkg::CPD_IDLE;
		end else begin
			unique case (state_q)
				cpd_pkg::CPD_IDLE: begin
					if (take && cond_ok) begin
						state_q <= cpd_pkg::CPD_OFFER;
					end
				end
				cpd_pkg::CPD_OFFER: begin
					// Data operation ends on acceptance, never on completion
					if (link.req_accept) begin
						state_q <= load_q || instr_q[cpd_pkg::CLS_HI:cpd_pkg::XF_CLS_LO]
						           == cpd_pkg::XFER_CODE ? cpd_pkg::CPD_XREQ
						                                 : cpd_pkg::CPD_IDLE;
					end else if (busy_q == cpd_pkg::NO_CP_LIMIT) begin
						state_q <= cpd_pkg::CPD_IDLE;
					end
				end
				cpd_pkg::CPD_XREQ: begin
					state_q <= cpd_pkg::CPD_XWAIT;
				end
				cpd_pkg::CPD_XWAIT: begin
					if (mem_ack_i) begin
						state_q <= cpd_pkg::CPD_XGAP;
					end
				end
				cpd_pkg::CPD_XGAP: begin
					// Count was lowered at the last ack, so the final gap sees zero
					state_q <= left_q == cpd_pkg::SHORT_WORDS - 5'h01 ? cpd_pkg::CPD_IDLE
					                                                  : cpd_pkg::CPD_XREQ;
				end
				default: begin
					state_q <= cpd_pkg::CPD_IDLE;
				end
			endcase
		end
	end

	// Ready only while idle, so one instruction is in flight at a time
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			instr_ready_o <= 1'b0;
		end else begin
			instr_ready_o <= (state_q == cpd_pkg::CPD_IDLE) && !(take && cond_ok);
		end
	end

	// Trap for every executed coprocessor instruction; failed ones are skipped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			undef_trap_o <= 1'b0;
			skip_o       <= 1'b0;
		end else begin
			undef_trap_o <= take && cond_ok;
			skip_o       <= take && !cond_ok;
		end
	end

	// ==========================================================
	// Offer to the coprocessor, count busy-wait cycles
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.req_valid <= 1'b0;
			link.req_instr <= cpd_pkg::ZERO_WORD;
			busy_q         <= cpd_pkg::ZERO_CNT;
		end else if (take && cond_ok) begin
			link.req_valid <= 1'b1;
			link.req_instr <= instr_i;
			busy_q         <= cpd_pkg::ZERO_CNT;
		end else if (state_q == cpd_pkg::CPD_OFFER) begin
			if (link.req_accept || busy_q == cpd_pkg::NO_CP_LIMIT) begin
				link.req_valid <= 1'b0;
			end else begin
				busy_q <= busy_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// Word transfers: address from the core, count from the coprocessor
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			left_q      <= 5'h00;
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= cpd_pkg::ZERO_WORD;
			mem_wdata_o <= cpd_pkg::ZERO_WORD;
		end else begin
			if (take && cond_ok) begin
				// Pre-indexed uses the moved base, post-indexed the old one
				mem_addr_o <= instr_i[cpd_pkg::PRE_BIT] ? moved_base : base_i;
			end
			if (state_q == cpd_pkg::CPD_OFFER && link.req_accept) begin
				left_q <= link.xfer_words;
			end
			if (state_q == cpd_pkg::CPD_XREQ) begin
				mem_req_o   <= 1'b1;
				mem_we_o    <= !load_q;
				mem_wdata_o <= link.st_data;
			end
			if (state_q == cpd_pkg::CPD_XWAIT && mem_ack_i) begin
				mem_req_o  <= 1'b0;
				mem_we_o   <= 1'b0;
				mem_addr_o <= mem_addr_o + cpd_pkg::WORD_STEP;
				left_q     <= left_q - 5'h01;
			end
		end
	end

	// Each finished word is handed across for one cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.word_strobe <= 1'b0;
			link.ld_data     <= cpd_pkg::ZERO_WORD;
		end else begin
			link.word_strobe <= state_q == cpd_pkg::CPD_XWAIT && mem_ack_i;
			if (state_q == cpd_pkg::CPD_XWAIT && mem_ack_i && load_q) begin
				link.ld_data <= mem_rdata_i;
			end
		end
	end

	// ==========================================================
	// Completion and base write-back
	logic fin;
	assign fin = (state_q == cpd_pkg::CPD_OFFER && link.req_accept && !(load_q
	             || instr_q[cpd_pkg::CLS_HI:cpd_pkg::XF_CLS_LO] == cpd_pkg::XFER_CODE))
	             || (state_q == cpd_pkg::CPD_OFFER && !link.req_accept
	             && busy_q == cpd_pkg::NO_CP_LIMIT)
	             || (state_q == cpd_pkg::CPD_XGAP && left_q == cpd_pkg::SHORT_WORDS - 5'h01);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o        <= 1'b0;
			wb_en_o       <= 1'b0;
			wb_value_o    <= cpd_pkg::ZERO_WORD;
			busy_cycles_o <= cpd_pkg::ZERO_CNT;
		end else begin
			done_o     <= fin;
			wb_en_o    <= fin && wb_q && state_q == cpd_pkg::CPD_XGAP;
			wb_value_o <= new_base_q;
			if (fin) begin
				busy_cycles_o <= busy_q;
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/cpd_cop.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpd_cop (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  cp_id_i,
	input  wire logic        stall_i,
	input  wire logic [3:0]  rd_sel_i,
	output logic [31:0]      rd_data_o,
	output logic             op_done_o,
	cpd_if.cop               link
);
	// ==========================================================
	// Register file and acceptance
	logic [31:0] regs_q [16];
	logic [3:0]  ptr_q;
	logic        load_q;
	logic        op_pend_q;
	logic [31:0] op_instr_q;
	logic        mine;
	logic        is_xfer;

	// Only its own number is honoured; the rest of the word is free
	assign mine    = link.req_instr[cpd_pkg::NUM_HI:cpd_pkg::NUM_LO] == cp_id_i;
	assign is_xfer = link.req_instr[cpd_pkg::CLS_HI:cpd_pkg::XF_CLS_LO] == cpd_pkg::XFER_CODE;
	assign link.st_data = regs_q[ptr_q];

	// Stall stretches the core's busy-wait loop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.req_accept <= 1'b0;
			link.xfer_words <= cpd_pkg::SHORT_WORDS;
		end else begin
			link.req_accept <= link.req_valid && mine && !stall_i && !link.req_accept;
			link.xfer_words <= link.req_instr[cpd_pkg::LEN_BIT] ? cpd_pkg::LONG_WORDS
			                                                    : cpd_pkg::SHORT_WORDS;
		end
	end

	// Transfer pointer starts at the target register and walks upward
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_q  <= 4'h0;
			load_q <= 1'b0;
		end else if (link.req_valid && mine && !link.req_accept && is_xfer) begin
			ptr_q  <= link.req_instr[cpd_pkg::TGT_HI:cpd_pkg::TGT_LO];
			load_q <= link.req_instr[cpd_pkg::LOAD_BIT];
		end else if (link.word_strobe) begin
			ptr_q <= ptr_q + 4'h1;
		end
	end

	// One queued data operation, run after the core has moved on
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_pend_q  <= 1'b0;
			op_instr_q <= cpd_pkg::ZERO_WORD;
			op_done_o  <= 1'b0;
		end else begin
			op_done_o <= op_pend_q;
			op_pend_q <= link.req_accept && !is_xfer;
			if (link.req_valid && !link.req_accept) begin
				op_instr_q <= link.req_instr;
			end
		end
	end

	// ==========================================================
	// Register writes: loaded words and operation results
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] res;
	assign a = regs_q[op_instr_q[cpd_pkg::FSRC_HI:cpd_pkg::FSRC_LO]];
	assign b = regs_q[op_instr_q[cpd_pkg::SSRC_HI:cpd_pkg::SSRC_LO]];

	always_comb begin
		unique case (op_instr_q[cpd_pkg::OPC_HI:cpd_pkg::OPC_LO])
			cpd_pkg::OPC_ADD: res = a + b;
			cpd_pkg::OPC_SUB: res = a - b;
			cpd_pkg::OPC_AND: res = a & b;
			cpd_pkg::OPC_OR:  res = a | b;
			default:          res = a ^ b;
		endcase
	end

	for (genvar i = 0; i < 16; i++) begin : g_reg
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				regs_q[i] <= cpd_pkg::ZERO_WORD;
			end else if (link.word_strobe && load_q && ptr_q == 4'(i)) begin
				regs_q[i] <= link.ld_data;
			end else if (op_pend_q
			             && op_instr_q[cpd_pkg::TGT_HI:cpd_pkg::TGT_LO] == 4'(i)) begin
				regs_q[i] <= res;
			end
		end
	end

	// Readback port for the user side
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= cpd_pkg::ZERO_WORD;
		end else begin
			rd_data_o <= regs_q[rd_sel_i];
		end
	end
endmodule
`default_nettype wire

// *** test/cpd_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpd_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        req_valid_i,
	input wire logic [31:0] req_instr_i,
	input wire logic        req_accept_i,
	input wire logic [4:0]  xfer_words_i,
	input wire logic        word_strobe_i
);
	// ==========================================================
	// Offer age, so a core that never gives up shows at once
	logic [7:0] age_q;

	// Counts offer cycles without an accept
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			age_q <= 8'h00;
		end else if (req_valid_i && !req_accept_i) begin
			age_q <= age_q + 8'h01;
		end else begin
			age_q <= 8'h00;
		end
	end

	// ==========================================================
	// Link properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_offer;
		req_valid_i && !req_accept_i;
	endsequence

	sequence s_dop_taken;
		req_accept_i && req_instr_i[27:24] == 4'he;
	endsequence

	a_offer_class: assert property (
		req_valid_i |-> (req_instr_i[27:24] == 4'he && !req_instr_i[4])
		|| req_instr_i[27:25] == 3'h6)
		else $error("offer of a non-coprocessor word");
	a_instr_stable: assert property (
		s_offer |=> !req_valid_i || $stable(req_instr_i))
		else $error("offered word changed before accept");
	a_accept_cause: assert property (
		req_accept_i |-> $past(req_valid_i) && !$past(req_accept_i))
		else $error("accept without a pending offer");
	a_accept_pulse: assert property (
		req_accept_i |=> !req_accept_i)
		else $error("accept longer than one cycle");
	a_dop_release: assert property (
		s_dop_taken |=> !req_valid_i)
		else $error("core still waits after data op accept");
	a_words_legal: assert property (
		xfer_words_i == 5'h01 || xfer_words_i == 5'h10)
		else $error("word count outside the two lengths");
	a_strobe_gap: assert property (
		word_strobe_i |=> !word_strobe_i)
		else $error("word strobe without a gap");
	a_offer_bound: assert property (
		age_q <= 8'h41)
		else $error("offer outlived the busy-wait limit");
endmodule
`default_nettype wire

// *** test/cpd_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpd_tb;
	localparam logic [3:0]  CP = 4'h5;
	localparam logic [31:0] K  = 32'ha5a5_0000;
	logic        clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, stall_i = 1'b0;
	logic        mem_ack_i = 1'b0;
	logic [3:0]  flags_i = 4'h0, rd_sel_i = 4'h0;
	logic [31:0] instr_i = 32'h0, base_i = 32'h0, mem_rdata_i = 32'h0, wbv, rdv;
	logic        instr_ready_o, undef_trap_o, skip_o, done_o, wb_en_o, mem_req_o;
	logic        mem_we_o, op_done_o;
	logic [31:0] wb_value_o, mem_addr_o, mem_wdata_o, rd_data_o;
	logic [7:0]  busy_cycles_o;
	logic [31:0] a_q[$], d_q[$];
	logic        w_q[$];
	int          failures = 0, tests_run = 0, cyc = 0, n_trap, n_skip, n_done, n_opd, n_wb;

	cpd_if link_if();
	cpd_core cpd_core_i (
		.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.flags_i(flags_i), .base_i(base_i), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i), .instr_ready_o(instr_ready_o),
		.undef_trap_o(undef_trap_o), .skip_o(skip_o), .done_o(done_o), .wb_en_o(wb_en_o),
		.wb_value_o(wb_value_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.busy_cycles_o(busy_cycles_o), .link(link_if));
	cpd_cop cpd_cop_i (
		.clk_i(clk_i), .rst_i(rst_i), .cp_id_i(CP), .stall_i(stall_i), .rd_sel_i(rd_sel_i),
		.rd_data_o(rd_data_o), .op_done_o(op_done_o), .link(link_if));
	cpd_chk cpd_chk_i (
		.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(link_if.req_valid),
		.req_instr_i(link_if.req_instr), .req_accept_i(link_if.req_accept),
		.xfer_words_i(link_if.xfer_words), .word_strobe_i(link_if.word_strobe));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ==========================================================
	// Memory and event monitor; data is address-derived so words can be traced
	always @(posedge clk_i) begin
		cyc++;
		mem_ack_i <= mem_req_o === 1'b1 && !mem_ack_i;
		mem_rdata_i <= (mem_req_o === 1'b1 && !mem_ack_i) ? mem_addr_o ^ K : ~mem_rdata_i;
		if (mem_req_o === 1'b1 && mem_ack_i) begin
			a_q.push_back(mem_addr_o);
			d_q.push_back(mem_wdata_o);
			w_q.push_back(mem_we_o);
		end
		if (undef_trap_o === 1'b1) n_trap++;
		if (skip_o === 1'b1) n_skip++;
		if (done_o === 1'b1) n_done++;
		if (op_done_o === 1'b1) n_opd++;
		if (wb_en_o === 1'b1) begin
			n_wb++;
			wbv = wb_value_o;
		end
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end

	// ==========================================================
	// Access tasks
	function automatic logic [31:0] dop(input logic [3:0] c, o, a, t, n, b);
		return {c, 4'he, o, a, t, n, 3'h0, 1'b0, b};
	endfunction

	function automatic logic [31:0] xfr(input logic p, u, n, w, l,
			input logic [3:0] t, num, input logic [7:0] o);
		return {4'he, 3'h6, p, u, n, w, l, 4'h0, t, num, o};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Presents one word, then waits for completion or skip
	task automatic run(input logic [31:0] ins, input logic [3:0] fl, input logic [31:0] b);
		int i;
		do @(negedge clk_i); while (instr_ready_o !== 1'b1);
		n_trap = 0;
		n_skip = 0;
		n_done = 0;
		n_opd = 0;
		n_wb = 0;
		a_q.delete();
		d_q.delete();
		w_q.delete();
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= ins;
		flags_i <= fl;
		base_i <= b;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		i = 0;
		while (n_done + n_skip == 0 && i < 200) begin
			@(negedge clk_i);
			i++;
		end
		// A hung instruction counts against the run
		if (i == 200) failures++;
		repeat (3) @(negedge clk_i);
	endtask

	task automatic rd(input logic [3:0] r);
		@(posedge clk_i);
		rd_sel_i <= r;
		@(posedge clk_i);
		@(negedge clk_i);
		rdv = rd_data_o;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		logic [3:0]  fl[3];
		logic [15:0] pm[3];
		logic        pass;
		logic [31:0] mod, ea, e5, e6;
		fl = '{4'h0, 4'hf, 4'h8};
		pm = '{16'h56aa, 16'h6655, 16'h6a9a};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// Every condition code under three flag sets
		for (int f = 0; f < 3; f++) begin
			for (int c = 0; c < 16; c++) begin
				pass = pm[f][c];
				run(dop(c[3:0], 4'h0, 4'hf, 4'hf, CP, 4'hf), fl[f], 32'h0);
				chk(32'(n_trap), 32'(pass));
				chk(32'(n_skip), 32'(!pass));
				chk(32'(n_opd), 32'(pass));
				chk(32'(n_done), 32'(pass));
				if (pass) chk(32'(busy_cycles_o), 32'h1);
			end
		end
		// Single-word loads in all eight index modes, offset of three words
		for (int m = 0; m < 8; m++) begin
			mod = m[1] ? 32'h100c : 32'h0ff4;
			ea = m[2] ? mod : 32'h1000;
			run(xfr(m[2], m[1], 1'b0, m[0], 1'b1, m[3:0], CP, 8'h03), 4'h0, 32'h1000);
			chk(32'(a_q.size()), 32'h1);
			chk(32'(n_done), 32'h1);
			chk(a_q[0], ea);
			chk(32'(w_q[0]), 32'h0);
			chk(32'(n_wb), 32'(m[0]));
			if (m[0]) chk(wbv, mod);
			rd(m[3:0]);
			chk(rdv, ea ^ K);
		end
		// Arithmetic on loaded registers, second one with a busy coprocessor
		e5 = 32'h0ff4 ^ K;
		e6 = 32'h100c ^ K;
		run(dop(4'he, 4'h0, 4'h5, 4'h9, CP, 4'h6), 4'h0, 32'h0);
		rd(4'h9);
		chk(rdv, e5 + e6);
		@(posedge clk_i);
		stall_i <= 1'b1;
		fork
			begin
				repeat (8) @(posedge clk_i);
				stall_i <= 1'b0;
			end
		join_none
		run(dop(4'he, 4'h1, 4'h5, 4'ha, CP, 4'h6), 4'h0, 32'h0);
		chk(32'(n_opd), 32'h1);
		chk(32'(busy_cycles_o), 32'h7);
		rd(4'ha);
		chk(rdv, e5 - e6);
		// Foreign coprocessor number: trap, give-up, no effect
		run(dop(4'he, 4'h0, 4'h5, 4'h9, CP ^ 4'h1, 4'h6), 4'h0, 32'h0);
		chk(32'(n_trap), 32'h1);
		chk(32'(n_opd), 32'h0);
		chk(32'(busy_cycles_o), 32'(cpd_pkg::NO_CP_LIMIT));
		run(xfr(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0, CP ^ 4'h1, 8'h00), 4'h0, 32'h1000);
		chk(32'(a_q.size()), 32'h0);
		// Long store walks up a word at a time
		run(xfr(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, CP, 8'h00), 4'h0, 32'h2000);
		chk(32'(a_q.size()), 32'h10);
		for (int k = 0; k < a_q.size(); k++) begin
			chk(a_q[k], 32'h2000 + 32'(k) * 32'h4);
			chk(32'(w_q[k]), 32'h1);
		end
		chk(d_q[0], 32'h1000 ^ K);
		finish_test();
	end
endmodule
`default_nettype wire
